// [hw/ipie_pkg.sv]
// Shared constants and types of the I/O processor interruption unit
package ipie_pkg;
	// Clock and stall timing
	localparam int CLK_MHZ = 25;
	localparam int DLY_US = 256;
	localparam int DLY_CYC = DLY_US * CLK_MHZ;
	// Local scratch storage byte addresses
	localparam logic [7:0] LS_TIMER = 8'h50;
	localparam logic [7:0] LS_EXT_OLD = 8'h18;
	localparam logic [7:0] LS_SVC_OLD = 8'h20;
	localparam logic [7:0] LS_PGM_OLD = 8'h28;
	localparam logic [7:0] LS_MC_OLD = 8'h30;
	localparam logic [7:0] LS_NEW_OFS = 8'h40;
	localparam logic [7:0] LS_WORD = 8'h04;
	// Program status word bit positions, vector bit 63 is word bit 0
	localparam int PSW_SYS = 56;
	localparam int PSW_WAIT = 49;
	// Bits that an operational-mode load may change
	localparam logic [63:0] PSW_KEEP = 64'h01fb_ffff_f8ff_ffff;
	// Interruption codes
	localparam logic [15:0] CODE_TMR = 16'h0080;
	localparam logic [15:0] CODE_CE = 16'h0002;
	localparam logic [15:0] CODE_SPEC = 16'h0006;
	localparam logic [15:0] CODE_NONE = 16'h0000;
	// Direct write operation pattern
	localparam logic [3:0] WRD_CE_EXT = 4'h8;
	// Timer step per line-frequency pulse
	localparam logic [31:0] TMR_STEP = 32'h0000_0100;
	localparam logic [7:0] LOCK_ONES = 8'hff;
	// Register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STAT = 8'h04;
	localparam logic [7:0] REG_PSWH = 8'h08;
	localparam logic [7:0] REG_PSWL = 8'h0c;
	localparam logic [7:0] REG_TIMER = 8'h10;
	// Control register: bit 0 diagnostic mode, bits 7:4 communication
	localparam int CTRL_DIAG = 0;
	localparam int CTRL_COMM = 4;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_00f1;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	// Operations handed over by the instruction sequencer
	typedef enum logic [2:0] {
		OP_LDA, OP_WRD, OP_DLY, OP_TS, OP_LPSW, OP_SSM
	} ipie_op_t;
endpackage

// [hw/ipie_sync.sv]
// Two-stage synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module ipie_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q_r
);
	logic [W-1:0] meta_r;

	if (W < 1) begin : g_bad
		$error("ipie_sync: W must be positive");
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			q_r <= '0;
		end else begin
			meta_r <= d;
			q_r <= meta_r;
		end
	end
endmodule

// [hw/ipie_tick.sv]
// Free-running prescaler giving a one-cycle enable pulse
`timescale 1ns/1ps
module ipie_tick #(
	parameter int DIV = 6400
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Enable pulse
	output logic tick_r
);
	localparam int CW = $clog2(DIV + 1);
	logic [CW-1:0] cnt_r;

	if (DIV < 1) begin : g_bad
		$error("ipie_tick: DIV must be at least one");
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			tick_r <= 1'b0;
		end else if (cnt_r == CW'(DIV - 1)) begin
			cnt_r <= '0;
			tick_r <= 1'b1;
		end else begin
			cnt_r <= cnt_r + 1'b1;
			tick_r <= 1'b0;
		end
	end
endmodule

// [hw/ipie_core.sv]
// Interruption, interval timer and added instructions of the I/O processor
//
// Local design decisions: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
// Notes on behaviour
// - Interruption stores old word, loads new word; machine check stops instead.
// - Interruptions taken only between instructions.
// - Stop finishes instruction, keeps pending interruptions.
// - Machine-check mask comes only from controller.
// - Machine check saves old word at 48.
// - Timer is word 80; stores replace it.
// - Positive to negative timer raises external request.
// - Timer frozen while stopped by direct control.
// - Wait state keeps timer and its request.
// - Timer steps on line-frequency pulses.
// - Controller interrupt requests external, code bit 30.
// - Operational loads cannot change I/O, check masks.
// - Fetch address: low 24 bits, cc kept.
// - Subchannel from low eight address bits only.
// - Data address zero, then command, then next.
// - Direct write pattern 1000 interrupts the controller.
// - Other patterns: specification exception, suppressed.
// - Direct write sets control bits 7:4 (communication) in controller.
// - Direct write touches no storage, cc kept.
// - Stall 256 us per count; zero none.
// - Stall ends at zero or unmasked interruption.
// - Lock op: cc from bit 0, byte ones.
// - Lock op read and write are atomic.
// - External accepted only with mask bit 7.
module ipie_core
	import ipie_pkg::*;
#(
	parameter int DLY_CYCLES = DLY_CYC,
	parameter int NSUB = 256,
	parameter logic [3:0] PROC_BIT = 4'h1
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic nrst,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Instruction sequencer
	input wire logic ins_end,
	input wire logic pgm_req,
	input wire logic pgm_svc,
	input wire logic [15:0] pgm_code,
	input wire logic op_start,
	input wire ipie_op_t op_kind,
	input wire logic [7:0] op_field,
	input wire logic [23:0] op_addr,
	input wire logic [63:0] op_wval,
	output logic op_done,
	output logic op_supp,
	output logic [31:0] op_data,
	output logic op_dwe,
	output logic [1:0] op_cc,
	output logic op_ccwe,
	// Program stores into scratch storage
	input wire logic scr_wr,
	input wire logic [7:0] scr_addr,
	input wire logic [31:0] scr_wdata,
	// Scratch storage master
	output logic ls_req,
	output logic ls_we,
	output logic [7:0] ls_addr,
	output logic [31:0] ls_wdata,
	input wire logic ls_ack,
	input wire logic [31:0] ls_rdata,
	// Main storage byte master
	output logic mem_req,
	output logic mem_lock,
	output logic mem_we,
	output logic [23:0] mem_addr,
	output logic [7:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [7:0] mem_rdata,
	// Multiplexor subchannel events
	input wire logic sch_sio,
	input wire logic sch_xfer,
	input wire logic [7:0] sch_num,
	input wire logic [23:0] sch_ccw,
	// Controlling element pins and check logic
	input wire logic ce_stop,
	input wire logic ce_start,
	input wire logic ce_intr,
	input wire logic ce_mc_mask,
	input wire logic line_freq,
	input wire logic mc_event,
	output logic [3:0] ce_pir_set,
	output logic ce_ext_req,
	output logic mc_req,
	output logic proc_oper
);
	localparam int SW = $clog2(NSUB);
	typedef enum logic [3:0] {
		S_IDLE, S_OLD0, S_OLD1, S_NEW0, S_NEW1, S_DLY, S_TSR, S_TSW
	} ipie_st_t;

	if (NSUB < 2 || NSUB > 256 || (1 << SW) != NSUB) begin : g_bad
		$error("ipie_core: NSUB must be a power of two up to 256");
	end

	// Reset release
	logic rst1_r, rst_n_r;
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rst1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst1_r <= 1'b1;
			rst_n_r <= rst1_r;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n_r);

	// Pins from the controlling element are asynchronous
	logic [4:0] pin_s, pin_d_r;
	ipie_sync #(.W(5)) u_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n_r),
		.d({ce_stop, ce_start, ce_intr, ce_mc_mask, line_freq}),
		.q_r(pin_s)
	);
	logic dly_tick;
	ipie_tick #(.DIV(DLY_CYCLES)) u_tick (
		.sys_clk(sys_clk),
		.rst_n(rst_n_r),
		.tick_r(dly_tick)
	);
	wire [4:0] pin_rise = pin_s & ~pin_d_r;
	wire stop_rise = pin_rise[4];
	wire start_rise = pin_rise[3];
	wire ce_int_rise = pin_rise[2];
	wire ce_mask_s = pin_s[1];
	wire line_rise = pin_rise[0];

	// State
	ipie_st_t st_r, st_nxt;
	logic [63:0] psw_r, psw_nxt;
	logic [31:0] ctrl_r, timer_r, new_hi_r, wb_dat_r;
	logic [15:0] code_r, pcode_r;
	logic [7:0] old_a_r, cnt_r;
	logic oper_r, stop_pend_r, ext_tmr_r, ext_ce_r, pgm_pend_r;
	logic svc_r, mc_pend_r, mc_cls_r, mc_req_r, wb_ack_r;

	// Register bus decode
	wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_r;
	wire wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_r;
	wire sel_ctrl = wb_adr_i == REG_CTRL;
	wire sel_stat = wb_adr_i == REG_STAT;
	wire sel_pswh = wb_adr_i == REG_PSWH;
	wire sel_pswl = wb_adr_i == REG_PSWL;
	wire sel_tmr = wb_adr_i == REG_TIMER;
	wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire [31:0] ctrl_wv = ((ctrl_r & ~wmask) | (wb_dat_i & wmask))
		& CTRL_WMASK;
	wire [31:0] tmr_wv = (timer_r & ~wmask) | (wb_dat_i & wmask);
	wire busy = st_r != S_IDLE;
	wire [31:0] stat_w = {23'h0, busy, mc_req_r, mc_pend_r, stop_pend_r,
		pgm_pend_r, ext_ce_r, ext_tmr_r, oper_r};
	wire [31:0] rd_mux = sel_ctrl ? ctrl_r : sel_stat ? stat_w :
		sel_pswh ? psw_r[63:32] : sel_pswl ? psw_r[31:0] :
		sel_tmr ? timer_r : 32'h0000_0000;
	wire diag = ctrl_r[CTRL_DIAG];
	wire [3:0] comm = ctrl_r[CTRL_COMM +: 4];

	// Interval timer; a store always beats the step
	wire tmr_sw = scr_wr & (scr_addr == LS_TIMER);
	wire tmr_wb = wb_wr & sel_tmr;
	wire tmr_step = oper_r & line_rise;
	wire [31:0] tmr_nxt = tmr_sw ? scr_wdata : tmr_wb ? tmr_wv :
		tmr_step ? timer_r - TMR_STEP : timer_r;
	wire tmr_neg = ~timer_r[31] & tmr_nxt[31];

	// Boundary and interruption selection
	wire at_bnd = ~busy & oper_r & (ins_end | psw_r[PSW_WAIT]);
	wire mc_go = mc_pend_r & ce_mask_s;
	wire ext_any = ext_tmr_r | ext_ce_r;
	wire ext_go = ext_any & psw_r[PSW_SYS];
	wire stop_go = at_bnd & stop_pend_r;
	wire take = at_bnd & ~stop_pend_r & (mc_go | pgm_pend_r | ext_go);
	wire take_mc = take & mc_go;
	wire take_pgm = take & ~mc_go & pgm_pend_r;
	wire take_ext = take & ~mc_go & ~pgm_pend_r;
	wire [15:0] ext_code = (ext_tmr_r ? CODE_TMR : CODE_NONE) |
		(ext_ce_r ? CODE_CE : CODE_NONE);
	wire [7:0] old_a = take_mc ? LS_MC_OLD : take_pgm ?
		(svc_r ? LS_SVC_OLD : LS_PGM_OLD) : LS_EXT_OLD;
	wire [15:0] take_code = take_mc ? CODE_NONE : take_pgm ? pcode_r :
		ext_code;

	// Operations from the sequencer
	wire op_go = op_start & ~busy & ~take & ~stop_go;
	wire go_lda = op_go & (op_kind == OP_LDA);
	wire go_wrd = op_go & (op_kind == OP_WRD);
	wire go_dly = op_go & (op_kind == OP_DLY);
	wire go_ts = op_go & (op_kind == OP_TS);
	wire go_lpsw = op_go & (op_kind == OP_LPSW);
	wire go_ssm = op_go & (op_kind == OP_SSM);
	wire wrd_ok = op_field[7:4] == WRD_CE_EXT;
	wire wrd_bad = go_wrd & ~wrd_ok;
	wire [63:0] keep = diag ? {64{1'b1}} : PSW_KEEP;
	wire [63:0] ssm_keep = {keep[63:56], 56'h0};
	wire dly_end = (st_r == S_DLY) &
		(ext_go | mc_go | (dly_tick & cnt_r == 8'h01));
	wire pgm_set = pgm_req | wrd_bad;

	// Subchannel data addresses; valid bits make reset read as zero
	logic [23:0] dadr_mem [NSUB];
	logic [NSUB-1:0] dval_r;
	wire [SW-1:0] sch_i = sch_num[SW-1:0];
	wire [SW-1:0] lda_i = op_addr[SW-1:0];
	wire [23:0] lda_v = dval_r[lda_i] ? dadr_mem[lda_i] : 24'h000000;
	always_ff @(posedge sys_clk) begin
		if (sch_sio) begin
			dadr_mem[sch_i] <= sch_ccw;
		end else if (sch_xfer) begin
			dadr_mem[sch_i] <= dadr_mem[sch_i] + 24'h000001;
		end
	end

	// Next state
	always_comb begin
		st_nxt = st_r;
		psw_nxt = psw_r;
		case (st_r)
			S_IDLE: begin
				if (take) begin
					st_nxt = S_OLD0;
				end else if (go_dly && op_field != 8'h00) begin
					st_nxt = S_DLY;
				end else if (go_ts) begin
					st_nxt = S_TSR;
				end else if (go_lpsw) begin
					psw_nxt = (op_wval & keep) | (psw_r & ~keep);
				end else if (go_ssm) begin
					psw_nxt = (op_wval & ssm_keep) | (psw_r & ~ssm_keep);
				end
			end
			S_OLD0: st_nxt = ls_ack ? S_OLD1 : S_OLD0;
			S_OLD1: st_nxt = !ls_ack ? S_OLD1 : mc_cls_r ? S_IDLE : S_NEW0;
			S_NEW0: st_nxt = ls_ack ? S_NEW1 : S_NEW0;
			S_NEW1: begin
				if (ls_ack) begin
					st_nxt = S_IDLE;
					psw_nxt = ({new_hi_r, ls_rdata} & keep) |
						(psw_r & ~keep);
				end
			end
			S_DLY: st_nxt = dly_end ? S_IDLE : S_DLY;
			S_TSR: st_nxt = mem_ack ? S_TSW : S_TSR;
			S_TSW: st_nxt = mem_ack ? S_IDLE : S_TSW;
			default: st_nxt = S_IDLE;
		endcase
	end

	// Storage master requests follow the next state
	wire ls_st = st_nxt inside {S_OLD0, S_OLD1, S_NEW0, S_NEW1};
	wire ls_hi = st_nxt == S_OLD0 || st_nxt == S_NEW0;
	wire ls_new = st_nxt == S_NEW0 || st_nxt == S_NEW1;
	wire [7:0] ls_a = (take ? old_a : old_a_r) +
		(ls_new ? LS_NEW_OFS : 8'h00) + (ls_hi ? 8'h00 : LS_WORD);
	wire [15:0] code_now = take ? take_code : code_r;
	wire [31:0] ls_wd = ls_hi ? {psw_r[63:48], code_now} : psw_r[31:0];
	wire ts_st = st_nxt == S_TSR || st_nxt == S_TSW;

	always_ff @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			st_r <= S_IDLE;
			psw_r <= 64'h0;
			timer_r <= 32'h0;
			ctrl_r <= CTRL_RST;
			dval_r <= '0;
			pin_d_r <= 5'h00;
		end else begin
			st_r <= st_nxt;
			psw_r <= psw_nxt;
			timer_r <= tmr_nxt;
			ctrl_r <= (wb_wr && sel_ctrl) ? ctrl_wv : ctrl_r;
			dval_r <= dval_r | (sch_sio ? NSUB'(1) << sch_i : '0);
			pin_d_r <= pin_s;
		end
	end

	// Pending flags: a set in the clearing cycle wins
	always_ff @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			oper_r <= 1'b0;
			stop_pend_r <= 1'b0;
			ext_tmr_r <= 1'b0;
			ext_ce_r <= 1'b0;
			pgm_pend_r <= 1'b0;
			mc_pend_r <= 1'b0;
			mc_req_r <= 1'b0;
		end else begin
			oper_r <= (oper_r & ~stop_go & ~(ls_ack & st_r == S_OLD1 &
				mc_cls_r)) | (start_rise & ~busy);
			stop_pend_r <= (stop_pend_r & ~stop_go & ~start_rise) |
				stop_rise;
			ext_tmr_r <= (ext_tmr_r & ~take_ext) | tmr_neg;
			ext_ce_r <= (ext_ce_r & ~take_ext) | ce_int_rise;
			pgm_pend_r <= (pgm_pend_r & ~take_pgm) | pgm_set;
			mc_pend_r <= (mc_pend_r & ~take_mc) | (mc_event & oper_r);
			mc_req_r <= (mc_req_r & ~start_rise) | take_mc;
		end
	end

	// Captured interruption details and stall count
	always_ff @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			code_r <= 16'h0;
			pcode_r <= 16'h0;
			svc_r <= 1'b0;
			old_a_r <= 8'h00;
			mc_cls_r <= 1'b0;
			new_hi_r <= 32'h0;
			cnt_r <= 8'h00;
		end else begin
			if (take) begin
				code_r <= take_code;
				old_a_r <= old_a;
				mc_cls_r <= take_mc;
			end
			if (pgm_set) begin
				pcode_r <= wrd_bad ? CODE_SPEC : pgm_code;
				svc_r <= ~wrd_bad & pgm_svc;
			end
			if (st_r == S_NEW0 && ls_ack) begin
				new_hi_r <= ls_rdata;
			end
			if (go_dly) begin
				cnt_r <= op_field;
			end else if (st_r == S_DLY && dly_tick) begin
				cnt_r <= cnt_r - 8'h01;
			end
		end
	end

	// Registered outputs
	always_ff @(posedge sys_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			{ls_req, ls_we, ls_addr, ls_wdata} <= '0;
			{mem_req, mem_lock, mem_we, mem_addr, mem_wdata} <= '0;
			{op_done, op_supp, op_data, op_dwe, op_cc, op_ccwe} <= '0;
			{ce_pir_set, ce_ext_req} <= '0;
			{wb_ack_r, wb_dat_r} <= '0;
		end else begin
			ls_req <= ls_st;
			ls_we <= ls_st & ~ls_new;
			ls_addr <= ls_st ? ls_a : 8'h00;
			ls_wdata <= ls_st & ~ls_new ? ls_wd : 32'h0;
			mem_req <= ts_st;
			mem_lock <= ts_st;
			mem_we <= st_nxt == S_TSW;
			mem_addr <= go_ts ? op_addr : mem_addr;
			mem_wdata <= LOCK_ONES;
			op_done <= go_lda | go_wrd | go_lpsw | go_ssm | dly_end |
				(go_dly & op_field == 8'h00) |
				(st_r == S_TSW & mem_ack);
			op_supp <= wrd_bad;
			op_data <= {8'h00, lda_v};
			op_dwe <= go_lda;
			op_cc <= (st_r == S_TSR & mem_ack) ? {1'b0, mem_rdata[7]} :
				op_cc;
			op_ccwe <= st_r == S_TSW & mem_ack;
			ce_pir_set <= (go_wrd & wrd_ok) ? comm : 4'h0;
			ce_ext_req <= go_wrd & wrd_ok;
			wb_ack_r <= wb_req;
			wb_dat_r <= wb_req ? rd_mux : 32'h0;
		end
	end
	assign wb_ack_o = wb_ack_r;
	assign wb_dat_o = wb_dat_r;
	assign mc_req = mc_req_r;
	assign proc_oper = oper_r;

	a_bnd_only: assert property (st_r == S_IDLE ##1 st_r == S_OLD0 |->
		$past(ins_end) || $past(psw_r[PSW_WAIT]))
		else $error("interruption taken inside an instruction");
	a_old_code: assert property (st_r == S_OLD0 && ls_req |->
		ls_we && ls_wdata[15:0] == code_r)
		else $error("old word lacks the interruption code");
	a_mc_save: assert property (take_mc |=> ls_addr == LS_MC_OLD)
		else $error("machine check old word misplaced");
	a_tmr_store: assert property (tmr_sw |=> timer_r == $past(scr_wdata))
		else $error("timer store lost");
	a_tmr_ovf: assert property (tmr_neg |=> ext_tmr_r [*2] or
		(ext_tmr_r ##1 st_r == S_OLD0))
		else $error("timer sign change not requested");
	a_tmr_hold: assert property (!oper_r && !tmr_sw && !tmr_wb |=>
		$stable(timer_r))
		else $error("timer moved while stopped");
	a_ce_code: assert property (take_ext && ext_ce_r |=>
		code_r[1] && ls_wdata[1])
		else $error("controller interrupt code bit missing");
	a_ext_mask: assert property (ext_any && !psw_r[PSW_SYS] && !mc_go &&
		!pgm_pend_r |-> !take)
		else $error("masked external interruption taken");
	a_wrd_ok: assert property (go_wrd && wrd_ok |=> ce_ext_req &&
		ce_pir_set == comm && !op_ccwe && !ls_req && !mem_req)
		else $error("direct write did not signal controller");
	a_wrd_bad: assert property (wrd_bad |=> pgm_pend_r && op_supp &&
		!ce_ext_req && pcode_r == CODE_SPEC)
		else $error("bad direct write not excepted");
	a_dly_zero: assert property (go_dly && op_field == 8'h00 |=>
		op_done && st_r == S_IDLE)
		else $error("zero stall delayed");
	a_ts_lock: assert property (st_r == S_TSR && mem_ack |=>
		mem_lock && mem_we && mem_req [*1])
		else $error("lock dropped between fetch and store");
	a_lda_word: assert property (go_lda |=> op_dwe &&
		op_data[31:24] == 8'h00 && !op_ccwe)
		else $error("fetch address result malformed");
endmodule

// [dv/ipie_store_model.sv]
// Scratch and main storage model answering the unit's two masters
`timescale 1ns/1ps
module ipie_store_model (
	// Clock and pacing
	input wire logic sys_clk,
	input wire logic slow,
	// Scratch storage slave
	input wire logic ls_req,
	input wire logic ls_we,
	input wire logic [7:0] ls_addr,
	input wire logic [31:0] ls_wdata,
	output logic ls_ack,
	output logic [31:0] ls_rdata,
	// Main storage byte slave
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [23:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	output logic mem_ack,
	output logic [7:0] mem_rdata
);
	logic [31:0] ram [0:63];
	logic [7:0] mem [0:255];
	logic [2:0] ls_wt;
	logic [2:0] mem_wt;
	logic [2:0] lat;
	// Slow mode stretches every answer to show the unit waits on ack
	assign lat = slow ? 3'h3 : 3'h0;
	initial begin
		ls_ack = 1'b0;
		mem_ack = 1'b0;
		ls_rdata = 32'h0;
		mem_rdata = 8'h0;
		ls_wt = 3'h0;
		mem_wt = 3'h0;
		for (int i = 0; i < 256; i++) begin
			mem[i] = 8'h00;
			ram[i[5:0]] = 32'h0;
		end
	end
	// Data outside an ack toggles so a stale sample never looks valid
	always @(posedge sys_clk) begin
		if (ls_req && !ls_ack && ls_wt >= lat) begin
			ls_ack <= 1'b1;
			ls_wt <= 3'h0;
			ls_rdata <= ram[ls_addr[7:2]];
			if (ls_we)
				ram[ls_addr[7:2]] <= ls_wdata;
		end else begin
			ls_ack <= 1'b0;
			ls_rdata <= ~ls_rdata;
			ls_wt <= ls_req ? ls_wt + 3'h1 : 3'h0;
		end
		if (mem_req && !mem_ack && mem_wt >= lat) begin
			mem_ack <= 1'b1;
			mem_wt <= 3'h0;
			mem_rdata <= mem[mem_addr[7:0]];
			if (mem_we)
				mem[mem_addr[7:0]] <= mem_wdata;
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			mem_wt <= mem_req ? mem_wt + 3'h1 : 3'h0;
		end
	end
endmodule

// [dv/tb_ipie_core.sv]
// Self-checking bench for the I/O processor interruption unit
`timescale 1ns/1ps
module tb_ipie_core
	import ipie_pkg::*;
;
	logic sys_clk, nrst = 1'b0, slow = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0, ins_end = 1'b0, pgm_req = 1'b0, pgm_svc = 1'b0;
	logic op_start = 1'b0, scr_wr = 1'b0, sch_sio = 1'b0, sch_xfer = 1'b0;
	logic ce_stop = 1'b0, ce_start = 1'b0, ce_intr = 1'b0, line_freq = 1'b0;
	logic ce_mc_mask = 1'b0, mc_event = 1'b0;
	logic [7:0] wb_adr_i = 8'h0, op_field = 8'h0, scr_addr = 8'h0;
	logic [7:0] sch_num = 8'h0;
	logic [31:0] wb_dat_i = 32'h0, scr_wdata = 32'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic [15:0] pgm_code = 16'h0;
	ipie_op_t op_kind = OP_LDA;
	logic [23:0] op_addr = 24'h0, sch_ccw = 24'h0;
	logic [63:0] op_wval = 64'h0;
	logic wb_ack_o, op_done, op_supp, op_dwe, op_ccwe, ls_req, ls_we, ls_ack;
	logic mem_req, mem_lock, mem_we, mem_ack, ce_ext_req, mc_req, proc_oper;
	logic [31:0] wb_dat_o, op_data, ls_wdata, ls_rdata, rd, t0;
	logic [1:0] op_cc;
	logic [7:0] ls_addr, mem_wdata, mem_rdata;
	logic [23:0] mem_addr;
	logic [3:0] ce_pir_set, pir_seen;
	int err_total = 0, cmp_count = 0, cyc_n = 0, mem_n = 0, ext_n = 0, dur;
	int lk_n = 0;

	ipie_core #(.DLY_CYCLES(8)) i_ipie_core (.*);
	ipie_store_model i_ipie_store_model (.*);

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Run is under a thousand cycles; the ceiling only catches a hang
	always @(posedge sys_clk) begin
		cyc_n <= cyc_n + 1;
		if (mem_req === 1'b1)
			mem_n <= mem_n + 1;
		if (mem_lock === 1'b1)
			lk_n <= lk_n + 1;
		if (ce_ext_req === 1'b1) begin
			ext_n <= ext_n + 1;
			pir_seen <= ce_pir_set;
		end
		if (cyc_n == 20000) begin
			err_total++;
			give_verdict();
		end
	end

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hf;
		do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	task automatic op(input ipie_op_t k, input logic [7:0] f,
		input logic [23:0] a, input logic [63:0] v);
		@(posedge sys_clk);
		op_start <= 1'b1;
		op_kind <= k;
		op_field <= f;
		op_addr <= a;
		op_wval <= v;
		@(posedge sys_clk);
		op_start <= 1'b0;
		dur = 0;
		while (op_done !== 1'b1) begin
			@(posedge sys_clk);
			dur++;
		end
	endtask

	task automatic boundary(input int settle);
		@(posedge sys_clk);
		ins_end <= 1'b1;
		@(posedge sys_clk);
		ins_end <= 1'b0;
		repeat (settle) @(posedge sys_clk);
	endtask

	// Pins pass two flops, so each level is held several cycles
	task automatic pulse_pin(input int k);
		@(posedge sys_clk);
		case (k)
			0: ce_start <= 1'b1;
			1: ce_stop <= 1'b1;
			2: ce_intr <= 1'b1;
			default: line_freq <= 1'b1;
		endcase
		repeat (3) @(posedge sys_clk);
		ce_start <= 1'b0;
		ce_stop <= 1'b0;
		ce_intr <= 1'b0;
		line_freq <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask

	initial begin
		repeat (12) @(posedge sys_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		i_ipie_store_model.ram[26] = 32'h0000_0000;
		i_ipie_store_model.ram[27] = 32'h0000_0300;
		i_ipie_store_model.ram[22] = 32'h0100_0000;
		i_ipie_store_model.ram[23] = 32'h0000_0200;
		i_ipie_store_model.ram[24] = 32'h0100_0000;
		i_ipie_store_model.mem[16] = 8'h80;
		i_ipie_store_model.mem[17] = 8'h7f;
		wb(1'b0, REG_CTRL, 32'h0);
		chk(rd, CTRL_RST);
		wb(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		pulse_pin(0);
		wb(1'b0, REG_STAT, 32'h0);
		chk(rd[0], 1'b1);
		// Subchannel address before and after start and transfers
		op(OP_LDA, 8'h0, 24'hab_cd07, 64'h0);
		chk({op_dwe, op_ccwe, op_data}, 34'h2_0000_0000);
		@(posedge sys_clk);
		sch_sio <= 1'b1;
		sch_num <= 8'h07;
		sch_ccw <= 24'h12_34fe;
		@(posedge sys_clk);
		sch_sio <= 1'b0;
		op(OP_LDA, 8'h0, 24'hff_ff07, 64'h0);
		chk(op_data, 32'h0012_34fe);
		repeat (2) begin
			@(posedge sys_clk);
			sch_xfer <= 1'b1;
			@(posedge sys_clk);
			sch_xfer <= 1'b0;
		end
		op(OP_LDA, 8'h0, 24'h01_0007, 64'h0);
		chk({op_dwe, op_ccwe, op_data}, 34'h2_0012_3500);
		chk(mem_n, 0);
		// Every direct write pattern; only 1000 is valid
		wb(1'b1, REG_CTRL, 32'h0000_0050);
		for (int p = 0; p < 16; p++) begin
			op(OP_WRD, {p[3:0], 4'ha}, 24'h00_0010, 64'h0);
			chk({op_supp, op_ccwe}, {p != 8, 1'b0});
		end
		chk({ext_n[15:0], pir_seen}, {16'd1, 4'h5});
		chk(mem_n, 0);
		boundary(30);
		chk(i_ipie_store_model.ram[10][15:0], CODE_SPEC);
		wb(1'b0, REG_PSWL, 32'h0);
		chk(rd, 32'h0000_0300);
		// Masked external stays pending until mask and boundary
		pulse_pin(2);
		boundary(30);
		wb(1'b0, REG_STAT, 32'h0);
		chk(rd[2], 1'b1);
		op(OP_LPSW, 8'h0, 24'h0, 64'h0100_0000_0000_0400);
		wb(1'b0, REG_PSWL, 32'h0);
		chk(rd, 32'h0000_0400);
		boundary(30);
		chk(i_ipie_store_model.ram[6], 32'h0100_0002);
		chk(i_ipie_store_model.ram[7][23:0], 24'h00_0400);
		wb(1'b0, REG_PSWL, 32'h0);
		chk(rd, 32'h0000_0200);
		// Timer store, line step and sign change
		@(posedge sys_clk);
		scr_wr <= 1'b1;
		scr_addr <= LS_TIMER;
		scr_wdata <= 32'h0000_0080;
		@(posedge sys_clk);
		scr_wr <= 1'b0;
		wb(1'b0, REG_TIMER, 32'h0);
		chk(rd, 32'h0000_0080);
		pulse_pin(3);
		wb(1'b0, REG_TIMER, 32'h0);
		chk(rd, 32'(32'h0000_0080 - TMR_STEP));
		wb(1'b0, REG_STAT, 32'h0);
		chk(rd[1], 1'b1);
		boundary(30);
		chk(i_ipie_store_model.ram[6][15:0], CODE_TMR);
		// Stop keeps pendings and freezes the timer; slow storage
		slow <= 1'b1;
		pulse_pin(1);
		pulse_pin(2);
		boundary(10);
		wb(1'b0, REG_STAT, 32'h0);
		chk(rd[2:0], 3'b100);
		wb(1'b0, REG_TIMER, 32'h0);
		t0 = rd;
		pulse_pin(3);
		wb(1'b0, REG_TIMER, 32'h0);
		chk(rd, t0);
		pulse_pin(0);
		boundary(60);
		chk(i_ipie_store_model.ram[6][15:0], CODE_CE);
		slow <= 1'b0;
		// Stall lengths and early end on an unmasked external
		op(OP_DLY, 8'h00, 24'h0, 64'h0);
		chk(dur == 1, 1'b1);
		op(OP_DLY, 8'h03, 24'h0, 64'h0);
		chk(dur >= 18 && dur <= 25, 1'b1);
		fork
			op(OP_DLY, 8'hc8, 24'h0, 64'h0);
			begin
				repeat (20) @(posedge sys_clk);
				pulse_pin(2);
			end
		join
		chk(dur < 100, 1'b1);
		boundary(30);
		// Lock byte: condition from leftmost bit, byte left all ones
		op(OP_TS, 8'h0, 24'h00_0010, 64'h0);
		chk({op_ccwe, op_cc}, 3'b101);
		op(OP_TS, 8'h0, 24'h00_0011, 64'h0);
		chk({op_ccwe, op_cc}, 3'b100);
		chk(i_ipie_store_model.mem[17], LOCK_ONES);
		chk({lk_n == mem_n, mem_n > 0}, 2'b11);
		// Operational loads cannot touch protected bits
		op(OP_LPSW, 8'h0, 24'h0, ~PSW_KEEP);
		wb(1'b0, REG_PSWH, 32'h0);
		chk(rd, 32'h0);
		op(OP_SSM, 8'h0, 24'h0, 64'hff00_0000_0000_0000);
		wb(1'b0, REG_PSWH, 32'h0);
		chk(rd, 32'h0100_0000);
		// Wait state: timer still steps, pending external taken
		op(OP_LPSW, 8'h0, 24'h0, 64'h0102_0000_0000_0500);
		wb(1'b0, REG_TIMER, 32'h0);
		t0 = rd;
		pulse_pin(3);
		wb(1'b0, REG_TIMER, 32'h0);
		chk(rd, 32'(t0 - TMR_STEP));
		pulse_pin(2);
		repeat (20) @(posedge sys_clk);
		chk(i_ipie_store_model.ram[7][23:0], 24'h00_0500);
		// Supervisor call stores its code at its own old slot
		@(posedge sys_clk);
		pgm_req <= 1'b1;
		pgm_svc <= 1'b1;
		pgm_code <= 16'h00a5;
		@(posedge sys_clk);
		pgm_req <= 1'b0;
		boundary(30);
		chk(i_ipie_store_model.ram[8], 32'h0100_00a5);
		// Machine check waits for the controller's mask, then stops
		@(posedge sys_clk);
		mc_event <= 1'b1;
		@(posedge sys_clk);
		mc_event <= 1'b0;
		boundary(30);
		ce_mc_mask <= 1'b1;
		wb(1'b0, REG_STAT, 32'h0);
		chk(rd[6:5], 2'b01);
		boundary(30);
		chk(i_ipie_store_model.ram[12], 32'h0100_0000);
		chk({mc_req, proc_oper}, 2'b10);
		// Diagnostic mode lets a load reach every bit
		wb(1'b1, REG_CTRL, 32'h0000_0051);
		op(OP_LPSW, 8'h0, 24'h0, 64'hfe04_0000_0700_0000);
		wb(1'b0, REG_PSWH, 32'h0);
		chk(rd, 32'hfe04_0000);
		give_verdict();
	end
endmodule
